// ---- hdl/rx_eq_lock_defs.vh ----
// Register offsets, field positions, reset values and timing for the receive-port control
`ifndef RX_EQ_LOCK_DEFS_VH
`define RX_EQ_LOCK_DEFS_VH

// Register offsets
`define PORT_SELECT_OFFSET      8'h4c
`define FS_QUALIFY_OFFSET       8'hbc
`define PORT_DEBUG_OFFSET       8'hd0
`define EQ_CTL2_OFFSET          8'hd2
`define EQUALIZER_CURRENT_SETTING_OFFSET        8'hd3
`define EQ_MANUAL_OFFSET        8'hd4
`define EQ_LIMITS_OFFSET        8'hd5

// Reset values
`define PORT_SELECT_RESET       8'h00
`define FS_QUALIFY_RESET        8'h80
`define PORT_DEBUG_RESET        8'h00
`define EQ_CTL2_RESET           8'h94
`define EQ_MANUAL_RESET         8'h60
`define EQ_LIMITS_RESET         8'hf2

// Port select field
`define PORT_SEL_BIT            0

// Port debug fields
`define DBG_SELFTEST_BIT        5
`define DBG_INJECT_CONT_BIT     1
`define DBG_INJECT_ONCE_BIT     0
`define DBG_WRITABLE_MASK       8'hdf

// Equalizer control two fields
`define CTL2_WAIT_MSB           7
`define CTL2_WAIT_LSB           5
`define CTL2_FIRST_LOCK_BIT     4
`define CTL2_RESTART_BIT        3
`define CTL2_FLOOR_EN_BIT       2
`define CTL2_WRITABLE_MASK      8'hf4
`define CTL2_STORED_MASK        8'hf4

// Manual override fields
`define MAN_UPPER_MSB           7
`define MAN_UPPER_LSB           5
`define MAN_LOCK_WAIT_BIT       4
`define MAN_LOWER_MSB           3
`define MAN_LOWER_LSB           1
`define MAN_SELECT_BIT          0

// Search limit fields
`define LIM_CEIL_MSB            7
`define LIM_CEIL_LSB            4
`define LIM_FLOOR_MSB           3
`define LIM_FLOOR_LSB           0

// Timing: shortest step wait, and the core clock period
`define EQ_WAIT_BASE_NS         164000
`define CORE_CLK_PERIOD_NS      10

`endif

// ---- hdl/eq_search_engine.v ----
// Adaptive equalizer search engine for one receive port
`include "rx_eq_lock_defs.vh"

module eq_search_engine #(
   parameter BASE_WAIT_CYCLES = `EQ_WAIT_BASE_NS / `CORE_CLK_PERIOD_NS
)(
   input  wire       core_clk_i,
   input  wire       rst_i,
   input  wire [2:0] wait_code_i,
   input  wire       first_lock_restart_i,
   input  wire       floor_enable_i,
   input  wire [3:0] floor_i,
   input  wire [3:0] ceiling_i,
   input  wire       restart_i,
   input  wire       manual_select_i,
   input  wire [2:0] manual_upper_i,
   input  wire [2:0] manual_lower_i,
   input  wire       lock_detect_i,
   output reg  [5:0] setting_o,
   output reg        adapt_done_o
);
   localparam [1:0] ST_SEARCH = 2'b01;
   localparam [1:0] ST_LOCKED = 2'b10;

   reg [1:0]  state_q;
   reg [3:0]  idx_q;
   reg [21:0] timer_q;
   reg        first_seen_q;
   reg        started_q;
   wire [3:0]  start_idx  = floor_enable_i ? floor_i : 4'h0;
   wire [21:0] wait_limit = BASE_WAIT_CYCLES[21:0] << wait_code_i;

   // Search: step one setting per expired wait, wrap to start past ceiling
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q      <= ST_SEARCH;
         idx_q        <= 4'h0;
         timer_q      <= 22'h000000;
         first_seen_q <= 1'b0;
         started_q    <= 1'b0;
         adapt_done_o <= 1'b0;
      end
      else if (!started_q)
      begin
         // RULE11 first search at floor; reset itself may only load constants
         started_q <= 1'b1;
         idx_q     <= start_idx;
         timer_q   <= 22'h000000;
      end
      else if (restart_i)
      begin
         // RULE9 restart from start
         state_q      <= ST_SEARCH;
         idx_q        <= start_idx;
         timer_q      <= 22'h000000;
         adapt_done_o <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_SEARCH:
            begin
               if (lock_detect_i && !first_seen_q && first_lock_restart_i)
               begin
                  // RULE8 first lock restart
                  first_seen_q <= 1'b1;
                  idx_q        <= 4'h0;
                  timer_q      <= 22'h000000;
               end
               else if (lock_detect_i)
               begin
                  first_seen_q <= 1'b1;
                  state_q      <= ST_LOCKED;
                  adapt_done_o <= 1'b1;
               end
               // RULE7 step wait time
               else if (timer_q + 22'h000001 >= wait_limit)
               begin
                  timer_q <= 22'h000000;
                  // RULE15 ceiling bound
                  if (idx_q >= ceiling_i)
                     idx_q <= start_idx;
                  else
                     idx_q <= idx_q + 4'h1;
               end
               else
                  timer_q <= timer_q + 22'h000001;
            end
            ST_LOCKED:
            begin
               if (!lock_detect_i)
               begin
                  state_q      <= ST_SEARCH;
                  timer_q      <= 22'h000000;
                  adapt_done_o <= 1'b0;
               end
            end
            default:
               state_q <= ST_SEARCH;
         endcase
      end
   end

   // Setting in use: manual fields win while bypassed
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         setting_o <= 6'h00;
      else if (manual_select_i)
         // RULE12 RULE14 manual setting
         setting_o <= {manual_upper_i, manual_lower_i};
      else
         // RULE16 floor start
         setting_o <= {2'b00, idx_q};
   end
endmodule

// ---- hdl/rx_port_equalizer_lock_control.v ----
// Per-port equalizer, lock, frame-start and back-channel error control with port-selected registers
`include "rx_eq_lock_defs.vh"

// What this block does
// RULE1: Register accesses reach only the receive port chosen by the port select register.
// RULE2: Raw mode frame start waits until frame valid held the programmed count.
// RULE3: Debug bit 5 reads whether the remote serializer runs self-test.
// RULE4: Continuous inject bit corrupts one bit in every back-channel frame.
// RULE5: Single inject bit corrupts one bit in exactly one back-channel frame.
// RULE6: After the single injection, nothing more until the bit rises again.
// RULE7: Search waits a coded time, 164 us doubling per code, before stepping.
// RULE8: First-lock mode restarts the search from zero at first receiver lock.
// RULE9: Writing one to the restart bit restarts adaptation from its start value.
// RULE10: The restart bit clears itself and always reads zero.
// RULE11: Floor enable makes adaptation start at the floor setting, not zero.
// RULE12: While bypassed, setting bits 5:3 come from the upper manual field.
// RULE13: Lock-mode bit makes reported lock wait for equalizer adaptation done.
// RULE14: While bypassed, setting bits 2:0 come from the lower manual field.
// RULE15: Search never passes the ceiling; host keeps ceiling above floor.
// RULE16: With floor enabled, the 4-bit floor field is the start setting.
// RULE17: The setting in use reads back as a 6-bit status value.
module rx_port_equalizer_lock_control #(
   parameter BASE_WAIT_CYCLES = `EQ_WAIT_BASE_NS / `CORE_CLK_PERIOD_NS
)(
   input  wire        core_clk_i,
   input  wire        rst_i,
   input  wire [7:0]  reg_addr_i,
   input  wire [7:0]  reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [7:0]  reg_rdata_o,
   output reg         reg_rvalid_o,
   input  wire [1:0]  lock_detect_i,
   input  wire [1:0]  raw_mode_i,
   input  wire [1:0]  frame_valid_signal_i,
   input  wire [1:0]  remote_selftest_i,
   input  wire [1:0]  bc_frame_start_i,
   output wire [1:0]  frame_start_o,
   output wire [1:0]  bc_error_inject_o,
   output wire [1:0]  rx_lock_o,
   output wire [11:0] equalizer_current_setting_o
);
   localparam NUM_PORTS = 2;

   reg  [7:0] port_select_q;
   reg  [7:0] fs_qualify_q [0:NUM_PORTS-1];
   reg  [7:0] debug_q      [0:NUM_PORTS-1];
   reg  [7:0] ctl2_q       [0:NUM_PORTS-1];
   reg  [7:0] manual_q     [0:NUM_PORTS-1];
   reg  [7:0] limits_q     [0:NUM_PORTS-1];
   reg  [7:0] fv_count_q   [0:NUM_PORTS-1];
   reg  [NUM_PORTS-1:0] fv_fired_q;
   reg  [NUM_PORTS-1:0] frame_start_q;
   reg  [NUM_PORTS-1:0] once_armed_q;
   reg  [NUM_PORTS-1:0] inject_q;
   reg  [NUM_PORTS-1:0] selftest_q;
   reg  [NUM_PORTS-1:0] restart_q;
   reg  [NUM_PORTS-1:0] rx_lock_q;
   wire [5:0] eq_setting [0:NUM_PORTS-1];
   wire [NUM_PORTS-1:0] eq_done;
   wire       cur_port = port_select_q[`PORT_SEL_BIT];

   // Write strobe for one port register, shared by every per-port write
   function port_write;
      input [31:0] port;
      input        sel;
      input        wr;
      input [7:0]  addr;
      input [7:0]  offset;
      begin
         port_write = wr && (addr == offset) && (port == {31'h00000000, sel});
      end
   endfunction

   // Port select register is global
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         port_select_q <= `PORT_SELECT_RESET;
      else if (reg_wr_i && reg_addr_i == `PORT_SELECT_OFFSET)
         port_select_q <= reg_wdata_i;
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p = p + 1)
      begin : g_port
         wire wr_fs   = port_write(p, cur_port, reg_wr_i, reg_addr_i, `FS_QUALIFY_OFFSET);
         wire wr_dbg  = port_write(p, cur_port, reg_wr_i, reg_addr_i, `PORT_DEBUG_OFFSET);
         wire wr_ctl2 = port_write(p, cur_port, reg_wr_i, reg_addr_i, `EQ_CTL2_OFFSET);
         wire wr_man  = port_write(p, cur_port, reg_wr_i, reg_addr_i, `EQ_MANUAL_OFFSET);
         wire wr_lim  = port_write(p, cur_port, reg_wr_i, reg_addr_i, `EQ_LIMITS_OFFSET);
         wire once_rise = wr_dbg && reg_wdata_i[`DBG_INJECT_ONCE_BIT]
                          && !debug_q[p][`DBG_INJECT_ONCE_BIT];

         // RULE1 per-port register copies
         always @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               fs_qualify_q[p] <= `FS_QUALIFY_RESET;
               debug_q[p]      <= `PORT_DEBUG_RESET;
               ctl2_q[p]       <= `EQ_CTL2_RESET;
               manual_q[p]     <= `EQ_MANUAL_RESET;
               limits_q[p]     <= `EQ_LIMITS_RESET;
               restart_q[p]    <= 1'b0;
            end
            else
            begin
               if (wr_fs)
                  fs_qualify_q[p] <= reg_wdata_i;
               if (wr_dbg)
                  debug_q[p] <= reg_wdata_i & `DBG_WRITABLE_MASK;
               // RULE10 restart never stored
               if (wr_ctl2)
                  ctl2_q[p] <= reg_wdata_i & `CTL2_STORED_MASK;
               if (wr_man)
                  manual_q[p] <= reg_wdata_i;
               if (wr_lim)
                  limits_q[p] <= reg_wdata_i;
               // RULE9 one-cycle restart pulse
               restart_q[p] <= wr_ctl2 && reg_wdata_i[`CTL2_RESTART_BIT];
            end
         end

         // Raw-mode frame start qualification; one start per frame-valid period
         always @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               fv_count_q[p]    <= 8'h00;
               fv_fired_q[p]    <= 1'b0;
               frame_start_q[p] <= 1'b0;
            end
            else if (raw_mode_i[p] && frame_valid_signal_i[p])
            begin
               if (fv_count_q[p] != 8'hff)
                  fv_count_q[p] <= fv_count_q[p] + 8'h01;
               // RULE2 minimum frame valid
               if (!fv_fired_q[p] && ({1'b0, fv_count_q[p]} + 9'h001 >= {1'b0, fs_qualify_q[p]}))
               begin
                  fv_fired_q[p]    <= 1'b1;
                  frame_start_q[p] <= 1'b1;
               end
               else
                  frame_start_q[p] <= 1'b0;
            end
            else
            begin
               fv_count_q[p]    <= 8'h00;
               fv_fired_q[p]    <= 1'b0;
               frame_start_q[p] <= 1'b0;
            end
         end

         // Back-channel error injection; a fresh arm in the consuming cycle survives
         always @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               once_armed_q[p] <= 1'b0;
               inject_q[p]     <= 1'b0;
            end
            else
            begin
               // RULE4 RULE5 corrupt frame bit
               inject_q[p] <= bc_frame_start_i[p] &&
                              (debug_q[p][`DBG_INJECT_CONT_BIT] || once_armed_q[p]);
               // RULE6 rearm on rising write
               if (once_rise)
                  once_armed_q[p] <= 1'b1;
               else if (bc_frame_start_i[p])
                  once_armed_q[p] <= 1'b0;
            end
         end

         // Self-test flag and qualified lock
         always @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               selftest_q[p] <= 1'b0;
               rx_lock_q[p]  <= 1'b0;
            end
            else
            begin
               // RULE3 remote self-test flag
               selftest_q[p] <= remote_selftest_i[p];
               // RULE13 lock waits for equalizer
               if (manual_q[p][`MAN_LOCK_WAIT_BIT])
                  rx_lock_q[p] <= lock_detect_i[p] && eq_done[p];
               else
                  rx_lock_q[p] <= lock_detect_i[p];
            end
         end

         // RULE11 RULE16 floor start select
         eq_search_engine #(
            .BASE_WAIT_CYCLES (BASE_WAIT_CYCLES)
         ) u_eq (
            .core_clk_i           (core_clk_i),
            .rst_i                (rst_i),
            .wait_code_i          (ctl2_q[p][`CTL2_WAIT_MSB:`CTL2_WAIT_LSB]),
            .first_lock_restart_i (ctl2_q[p][`CTL2_FIRST_LOCK_BIT]),
            .floor_enable_i       (ctl2_q[p][`CTL2_FLOOR_EN_BIT]),
            .floor_i              (limits_q[p][`LIM_FLOOR_MSB:`LIM_FLOOR_LSB]),
            .ceiling_i            (limits_q[p][`LIM_CEIL_MSB:`LIM_CEIL_LSB]),
            .restart_i            (restart_q[p]),
            .manual_select_i      (manual_q[p][`MAN_SELECT_BIT]),
            .manual_upper_i       (manual_q[p][`MAN_UPPER_MSB:`MAN_UPPER_LSB]),
            .manual_lower_i       (manual_q[p][`MAN_LOWER_MSB:`MAN_LOWER_LSB]),
            .lock_detect_i        (lock_detect_i[p]),
            .setting_o            (eq_setting[p]),
            .adapt_done_o         (eq_done[p])
         );

         // Outputs are flop values
         assign frame_start_o[p]                   = frame_start_q[p];
         assign bc_error_inject_o[p]               = inject_q[p];
         assign rx_lock_o[p]                       = rx_lock_q[p];
         assign equalizer_current_setting_o[6*p+5 -: 6] = eq_setting[p];
      end
   endgenerate

   // Read mux for the selected port; unmapped offsets read zero
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         reg_rdata_o  <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i)
         begin
            case (reg_addr_i)
               `PORT_SELECT_OFFSET: reg_rdata_o <= port_select_q;
               `FS_QUALIFY_OFFSET:  reg_rdata_o <= fs_qualify_q[cur_port];
               `PORT_DEBUG_OFFSET:
                  reg_rdata_o <= debug_q[cur_port] |
                                 ({7'h00, selftest_q[cur_port]} << `DBG_SELFTEST_BIT);
               `EQ_CTL2_OFFSET:     reg_rdata_o <= ctl2_q[cur_port];
               // RULE17 setting in use
               `EQUALIZER_CURRENT_SETTING_OFFSET:   reg_rdata_o <= {2'b00, eq_setting[cur_port]};
               `EQ_MANUAL_OFFSET:   reg_rdata_o <= manual_q[cur_port];
               `EQ_LIMITS_OFFSET:   reg_rdata_o <= limits_q[cur_port];
               default:             reg_rdata_o <= 8'h00;
            endcase
         end
      end
   end
endmodule

// ---- verification/rx_port_eq_lock_properties.sv ----
// Concurrent checks on the receive-port control block ports
module rx_port_eq_lock_properties #(
   parameter BASE_WAIT_CYCLES = 8
)(
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic        reg_rvalid_o,
   input wire logic [1:0]  lock_detect_i,
   input wire logic [1:0]  raw_mode_i,
   input wire logic [1:0]  frame_valid_signal_i,
   input wire logic [1:0]  remote_selftest_i,
   input wire logic [1:0]  bc_frame_start_i,
   input wire logic [1:0]  frame_start_o,
   input wire logic [1:0]  bc_error_inject_o,
   input wire logic [1:0]  rx_lock_o,
   input wire logic [11:0] equalizer_current_setting_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain, so clocking and reset are given once
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   // Read answer arrives exactly one cycle after the strobe
   sequence s_answer;
      ##1 reg_rvalid_o;
   endsequence
   // A started frame must not pulse again in the next cycle
   sequence s_quiet0;
      ##1 !frame_start_o[0];
   endsequence

   a_read_answer: assert property (reg_rd_i |-> s_answer)
      else $error("read strobe got no answer next cycle");
   a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
      else $error("read answer without a read strobe");
   a_fs_cause0: assert property (
      frame_start_o[0] |-> $past(raw_mode_i[0] && frame_valid_signal_i[0]))
      else $error("port 0 frame start without raw frame valid");
   a_fs_cause1: assert property (
      frame_start_o[1] |-> $past(raw_mode_i[1] && frame_valid_signal_i[1]))
      else $error("port 1 frame start without raw frame valid");
   a_fs_single0: assert property (frame_start_o[0] |-> s_quiet0)
      else $error("port 0 frame start longer than one cycle");
   a_inject_cause0: assert property (
      bc_error_inject_o[0] |-> $past(bc_frame_start_i[0]))
      else $error("port 0 injection outside a back-channel frame");
   a_inject_cause1: assert property (
      bc_error_inject_o[1] |-> $past(bc_frame_start_i[1]))
      else $error("port 1 injection outside a back-channel frame");
   a_lock_cause0: assert property (rx_lock_o[0] |-> $past(lock_detect_i[0]))
      else $error("port 0 lock reported without detector lock");
   a_lock_drop1: assert property (!lock_detect_i[1] |=> !rx_lock_o[1])
      else $error("port 1 lock kept after detector dropped");
endmodule

bind rx_port_equalizer_lock_control rx_port_eq_lock_properties #(
   .BASE_WAIT_CYCLES(BASE_WAIT_CYCLES)
) props (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .lock_detect_i(lock_detect_i),
   .raw_mode_i(raw_mode_i), .frame_valid_signal_i(frame_valid_signal_i),
   .remote_selftest_i(remote_selftest_i), .bc_frame_start_i(bc_frame_start_i),
   .frame_start_o(frame_start_o), .bc_error_inject_o(bc_error_inject_o),
   .rx_lock_o(rx_lock_o), .equalizer_current_setting_o(equalizer_current_setting_o));

// ---- verification/remote_serializer_model.sv ----
// Behavioural model of the remote serializers on both links
module remote_serializer_model #(
   parameter int FRAME_GAP = 20
)(
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] lock_req_i,
   input  wire logic [1:0] selftest_req_i,
   output logic      [1:0] lock_o,
   output logic      [1:0] selftest_o,
   output logic      [1:0] bc_frame_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q;

   // Link status lags the request by a cycle; back-channel frames come at a fixed pace
   always @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_q <= 0;
         lock_o <= 2'h0;
         selftest_o <= 2'h0;
         bc_frame_o <= 2'h0;
      end
      else
      begin
         cnt_q <= (cnt_q == FRAME_GAP - 1) ? 0 : cnt_q + 1;
         lock_o <= lock_req_i;
         selftest_o <= selftest_req_i;
         bc_frame_o <= {2{cnt_q == 0}};
      end
   end
endmodule

// ---- verification/test_rx_port_equalizer_lock_control.sv ----
// Self-checking bench for the receive-port equalizer and lock control
module test_rx_port_equalizer_lock_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [1:0]  raw = 2'h0;
   logic [1:0]  fv = 2'h0;
   logic [1:0]  lock_req = 2'h0;
   logic [1:0]  st_req = 2'h0;
   wire  [7:0]  rdata;
   wire         rvalid;
   wire  [1:0]  lock, st, bcf, fs, inject, rx_lock;
   wire  [11:0] setting;
   int          fail_count = 0;
   int          num_checks = 0;

   // Short step wait keeps the search timing inside a brief run
   rx_port_equalizer_lock_control #(.BASE_WAIT_CYCLES(8)) dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
      .lock_detect_i(lock), .raw_mode_i(raw), .frame_valid_signal_i(fv),
      .remote_selftest_i(st), .bc_frame_start_i(bcf), .frame_start_o(fs),
      .bc_error_inject_o(inject), .rx_lock_o(rx_lock), .equalizer_current_setting_o(setting));
   remote_serializer_model peer (.core_clk_i(core_clk_i), .rst_i(rst_i),
      .lock_req_i(lock_req), .selftest_req_i(st_req), .lock_o(lock),
      .selftest_o(st), .bc_frame_o(bcf));

   always #5 core_clk_i = ~core_clk_i;

   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   task cycles(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_i);
      wr <= 1'b0;
   endtask

   // Read answer is taken one edge after the strobe, as the bus promises
   task rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_i);
      rd <= 1'b0;
      #1;
      chk("read valid", 8'h01, {7'h00, rvalid});
      chk(what, exp, rdata);
   endtask

   // Holds frame valid for len edges, then low; records first pulse edge and count
   task fv_run(input int p, input int len, output int first, output int pulses);
      first = 0;
      pulses = 0;
      @(posedge core_clk_i) fv[p] <= 1'b1;
      for (int i = 1; i <= len + 1; i++)
      begin
         @(posedge core_clk_i);
         if (i == len) fv[p] <= 1'b0;
         #1;
         if (fs[p] === 1'b1) pulses++;
         if (fs[p] === 1'b1 && first == 0) first = i;
      end
   endtask

   // Frames counted one cycle ahead of the injections that answer them
   task count_bc(input int p, output int nf, output int ni);
      nf = 0;
      ni = 0;
      for (int i = 0; i < 101; i++)
      begin
         @(posedge core_clk_i);
         #1;
         if (i < 100 && bcf[p] === 1'b1) nf++;
         if (i > 0 && inject[p] === 1'b1) ni++;
      end
   endtask

   task wait_step(output int c);
      logic [5:0] s;
      s = setting[5:0];
      c = 0;
      do
      begin
         @(posedge core_clk_i);
         #1;
         c++;
      end while (setting[5:0] === s && c < 64);
   endtask

   task t_reset;
      rd_chk("port select", 8'h4c, 8'h00);
      rd_chk("qualify time", 8'hbc, 8'h80);
      rd_chk("debug", 8'hd0, 8'h00);
      rd_chk("eq control", 8'hd2, 8'h94);
      rd_chk("manual", 8'hd4, 8'h60);
      rd_chk("limits", 8'hd5, 8'hf2);
      wr_reg(8'hbb, 8'hff);
      rd_chk("unmapped", 8'hbb, 8'h00);
      $display("reset values test finished");
   endtask

   task t_first_lock;
      wr_reg(8'h4c, 8'h01);
      wr_reg(8'hd4, 8'h70);
      wr_reg(8'hd2, 8'h1c);
      cycles(3);
      chk("floor start", 8'h02, {2'b00, setting[11:6]});
      @(posedge core_clk_i) lock_req[1] <= 1'b1;
      cycles(2);
      chk("lock waits", 8'h00, {7'h00, rx_lock[1]});
      cycles(4);
      chk("first lock setting", 8'h00, {2'b00, setting[11:6]});
      chk("lock shown", 8'h01, {7'h00, rx_lock[1]});
      @(posedge core_clk_i) lock_req[1] <= 1'b0;
      cycles(3);
      chk("lock gone", 8'h00, {7'h00, rx_lock[1]});
      $display("first lock test finished");
   endtask

   task t_frame;
      int f;
      int n;
      wr_reg(8'hbc, 8'h03);
      wr_reg(8'h4c, 8'h00);
      rd_chk("port 0 copy", 8'hbc, 8'h80);
      wr_reg(8'h4c, 8'h01);
      rd_chk("port 1 copy", 8'hbc, 8'h03);
      @(posedge core_clk_i) raw[1] <= 1'b1;
      fv_run(1, 6, f, n);
      chk("start delay", 8'h03, f[7:0]);
      chk("start count", 8'h01, n[7:0]);
      fv_run(1, 2, f, n);
      chk("short valid", 8'h00, n[7:0]);
      @(posedge core_clk_i) raw[1] <= 1'b0;
      fv_run(1, 6, f, n);
      chk("not raw", 8'h00, n[7:0]);
      wr_reg(8'h4c, 8'h00);
      wr_reg(8'hbc, 8'h01);
      @(posedge core_clk_i) raw[0] <= 1'b1;
      fv_run(0, 3, f, n);
      chk("port 0 start delay", 8'h01, f[7:0]);
      chk("port 0 start count", 8'h01, n[7:0]);
      $display("frame start test finished");
   endtask

   task t_eq;
      int c;
      wr_reg(8'h4c, 8'h00);
      wr_reg(8'hd5, 8'h32);
      wr_reg(8'hd2, 8'h2c);
      cycles(3);
      chk("restart at floor", 8'h02, {2'b00, setting[5:0]});
      rd_chk("restart clears", 8'hd2, 8'h24);
      wait_step(c);
      wait_step(c);
      chk("step wait", 8'h10, c[7:0]);
      c = 0;
      repeat (100)
      begin
         @(posedge core_clk_i);
         #1;
         if (setting[5:0] > c) c = setting[5:0];
      end
      chk("ceiling", 8'h03, c[7:0]);
      wr_reg(8'hd4, 8'ha7);
      cycles(3);
      chk("manual setting", 8'h2b, {2'b00, setting[5:0]});
      rd_chk("manual status", 8'hd3, 8'h2b);
      wr_reg(8'hd4, 8'h60);
      wr_reg(8'hd2, 8'h08);
      cycles(3);
      chk("no floor", 8'h00, {2'b00, setting[5:0]});
      $display("equalizer test finished");
   endtask

   task t_debug;
      @(posedge core_clk_i);
      st_req[0] <= 1'b1;
      lock_req[0] <= 1'b1;
      cycles(3);
      chk("port 0 lock", 8'h01, {7'h00, rx_lock[0]});
      rd_chk("selftest flag", 8'hd0, 8'h20);
      wr_reg(8'hd0, 8'hdc);
      rd_chk("debug stored", 8'hd0, 8'hfc);
      @(posedge core_clk_i) st_req[0] <= 1'b0;
      cycles(3);
      wr_reg(8'hd0, 8'h20);
      rd_chk("flag read only", 8'hd0, 8'h00);
      $display("debug test finished");
   endtask

   task t_inject;
      int nf;
      int ni;
      wr_reg(8'hd0, 8'h01);
      count_bc(0, nf, ni);
      chk("single shot", 8'h01, ni[7:0]);
      wr_reg(8'hd0, 8'h01);
      count_bc(0, nf, ni);
      chk("no rearm", 8'h00, ni[7:0]);
      wr_reg(8'hd0, 8'h00);
      wr_reg(8'hd0, 8'h01);
      count_bc(0, nf, ni);
      chk("rearmed", 8'h01, ni[7:0]);
      // Port 1 injects alongside so its injection check sees traffic
      wr_reg(8'h4c, 8'h01);
      wr_reg(8'hd0, 8'h02);
      wr_reg(8'h4c, 8'h00);
      wr_reg(8'hd0, 8'h02);
      count_bc(0, nf, ni);
      chk("frames", 8'h05, nf[7:0]);
      chk("continuous", 8'h05, ni[7:0]);
      $display("injection test finished");
   endtask

   initial
   begin
      repeat (4) @(posedge core_clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_first_lock;
      t_frame;
      t_eq;
      t_debug;
      t_inject;
      wrap_up;
   end

   // Whole run needs about 700 cycles; cut a hang at 10000
   initial
   begin
      #100000;
      fail_count++;
      wrap_up;
   end
endmodule
